/* File: design/lsf_config_top.sv */
// configuration registers, main group fade and sink grouping of the led sink driver
//
// Functional notes
// R1: sub group sinks share sub level current
// R2: third group sinks share third level current
// R3: level code decodes to documented current steps
// R4: grouped sink conducts only when enabled
// R5: host keeps sub/third level top bit zero
// R6: host writes only two fade bits
// R7: fade code selects 8, 16, 32 ms steps
// R8: only main group fades; others jump
// R9: new main code ramps step by step
// R10: step count equals code difference
// R11: ramp time is steps times interval
// R12: host writes only three grouping bits
// R13: grouping codes 000 to 011 map sinks
// R14: grouping codes 100, 101, 11x map sinks
// R15: grouping resets to all main
// R16: every sink stays individually disableable
// R17: three groups hold independent levels together
// R18: registers write-only, no read-back
// R19: write is address burst then data burst
// R20: per-sink enable bits active high, independent
// R21: rewrite mid-ramp continues from present code
// R22: sub, third, fade reset to zero
`timescale 1ns/1ps
module lsf_config_top #(
  parameter int MS_TICK_CYCLES = lsf_pkg::MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wrValid,
  input wire logic [5:0] wrAddr,
  input wire logic [5:0] wrData,
  output logic [4:0] sinkActive,
  output logic [4:0][5:0] sinkCurrent,
  output logic [4:0] mainLevelCode,
  output logic fadeBusy
);
  import lsf_pkg::*;

  // ==========================================================
  // write-only registers
  logic [4:0] sinkEnable_q;
  logic [4:0] mainTarget_q;
  logic [4:0] subLevel_q;
  logic [4:0] thirdLevel_q;
  lsf_fade_t fadeRate_q;
  logic [2:0] groupMap_q;
  logic mainWrite;

  // data burst pairs with the address burst in the link decoder; one strobe per write
  assign mainWrite = wrValid && (wrAddr == ADDR_MAIN_LEVEL); // [R19]

  // no read path exists; state is seen only through sink outputs, mainLevelCode and fadeBusy
  always_ff @(posedge core_clk) begin // [R18]
    if (sys_rst) begin
      sinkEnable_q <= RST_ENABLE;
      mainTarget_q <= RST_LEVEL;
      subLevel_q <= RST_LEVEL; // [R22]
      thirdLevel_q <= RST_LEVEL; // [R22]
      fadeRate_q <= FADE_OFF; // [R22]
      groupMap_q <= RST_MAP; // [R15]
    end else if (wrValid) begin
      // upper bits must be written zero by the host; they are dropped here
      case (wrAddr)
        ADDR_SINK_ENABLE: sinkEnable_q <= wrData[4:0]; // [R20]
        ADDR_MAIN_LEVEL: mainTarget_q <= wrData[4:0];
        ADDR_SUB_GROUP_LEVEL: subLevel_q <= wrData[4:0]; // [R5] [R17]
        ADDR_THIRD_GROUP_LEVEL: thirdLevel_q <= wrData[4:0]; // [R5] [R17]
        ADDR_MAIN_FADE_CONTROL: fadeRate_q <= lsf_fade_t'(wrData[1:0]); // [R6]
        ADDR_SINK_GROUP_MAP: groupMap_q <= wrData[2:0]; // [R12]
        default: ;
      endcase
    end
  end

  // ==========================================================
  // fade step timing
  logic msTick;
  logic [5:0] stepMs;
  logic [5:0] msCount_q;
  logic stepDue;
  logic ramping;
  logic timerRestart;

  always_comb begin
    case (fadeRate_q)
      FADE_8MS: stepMs = STEP_MS_SLOW; // [R7]
      FADE_16MS: stepMs = STEP_MS_MID; // [R7]
      FADE_32MS: stepMs = STEP_MS_FAST; // [R7]
      default: stepMs = 6'h00;
    endcase
  end

  assign ramping = (mainLevelCode != mainTarget_q);
  // timer restarts only when a ramp starts from rest, so a rewrite mid-ramp keeps its pace
  assign timerRestart = mainWrite && !ramping; // [R21]
  // at or past the interval, so a rate cut mid-ramp does not wait for the count to wrap
  assign stepDue = msTick && (msCount_q >= stepMs - 6'h01);

  lsf_ms_tick #(
    .TICK_CYCLES(MS_TICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .restart(timerRestart),
    .tick(msTick)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst || timerRestart || !ramping) begin
      msCount_q <= 6'h00;
    end else if (stepDue) begin
      msCount_q <= 6'h00;
    end else if (msTick) begin
      msCount_q <= msCount_q + 6'h01;
    end
  end

  // ==========================================================
  // present main code: one code step per interval, jump when fade is off
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mainLevelCode <= RST_LEVEL;
    end else if (fadeRate_q == FADE_OFF) begin
      mainLevelCode <= mainTarget_q; // [R7]
    end else if (ramping && stepDue) begin // [R9] [R11]
      if (mainTarget_q > mainLevelCode)
        mainLevelCode <= mainLevelCode + 5'h01; // [R10]
      else
        mainLevelCode <= mainLevelCode - 5'h01; // [R10] [R21]
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      fadeBusy <= 1'b0;
    else
      fadeBusy <= (fadeRate_q != FADE_OFF) && ramping;
  end

  // ==========================================================
  // grouping map
  lsf_group_t sinkGroup [SINKS];

  always_comb begin
    for (int i = 0; i < SINKS; i++)
      sinkGroup[i] = GRP_MAIN;
    case (groupMap_q)
      3'b001, 3'b100: begin // [R13] [R14]
        sinkGroup[3] = GRP_SUB;
        sinkGroup[4] = GRP_SUB;
      end
      3'b010: begin // [R13]
        sinkGroup[2] = GRP_SUB;
        sinkGroup[3] = GRP_SUB;
        sinkGroup[4] = GRP_THIRD;
      end
      3'b011: begin // [R13]
        sinkGroup[2] = GRP_SUB;
        sinkGroup[3] = GRP_THIRD;
      end
      3'b101: begin // [R14]
        sinkGroup[4] = GRP_SUB;
      end
      default: ; // 000 and 11x keep all five on main [R13] [R14]
    endcase
  end

  // ==========================================================
  // per-sink output; sub and third levels bypass the fade
  for (genvar s = 0; s < SINKS; s++) begin : g_sink
    lsf_sink_out u_sink (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .group(sinkGroup[s]),
      .enable(sinkEnable_q[s]), // [R16]
      .mainCode(mainLevelCode),
      .subCode(subLevel_q), // [R8]
      .thirdCode(thirdLevel_q), // [R8]
      .active(sinkActive[s]),
      .currentHalfMa(sinkCurrent[s])
    );
  end

endmodule : lsf_config_top

/* File: design/lsf_ms_tick.sv */
// one millisecond time base, a pulse every tickCycles clocks
`timescale 1ns/1ps
module lsf_ms_tick #(
  parameter int TICK_CYCLES = lsf_pkg::MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic restart,
  output logic tick
);
  import lsf_pkg::*;

  logic [31:0] count_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst || restart) begin
      count_q <= 32'h0;
      tick <= 1'b0;
    end else if (count_q == 32'(TICK_CYCLES - 1)) begin
      count_q <= 32'h0;
      tick <= 1'b1;
    end else begin
      count_q <= count_q + 32'h1;
      tick <= 1'b0;
    end
  end

endmodule : lsf_ms_tick

/* File: design/lsf_pkg.sv */
// shared constants and types for the led sink current and fade block
package lsf_pkg;

  // ==========================================================
  // register addresses (pulse count of the address burst)
  localparam logic [5:0] ADDR_SINK_ENABLE = 6'h00;
  localparam logic [5:0] ADDR_MAIN_LEVEL = 6'h01;
  localparam logic [5:0] ADDR_SUB_GROUP_LEVEL = 6'h02;
  localparam logic [5:0] ADDR_THIRD_GROUP_LEVEL = 6'h03;
  localparam logic [5:0] ADDR_MAIN_FADE_CONTROL = 6'h04;
  localparam logic [5:0] ADDR_SINK_GROUP_MAP = 6'h05;

  // ==========================================================
  // field layout and reset values
  localparam int LEVEL_W = 5;
  localparam int FADE_W = 2;
  localparam int MAP_W = 3;
  localparam int SINKS = 5;
  localparam int CUR_W = 6;
  localparam logic [4:0] RST_LEVEL = 5'h00;
  localparam logic [1:0] RST_FADE = 2'h0;
  localparam logic [2:0] RST_MAP = 3'h0;
  localparam logic [4:0] RST_ENABLE = 5'h00;

  // ==========================================================
  // level code decode points, current in half milliamp units
  localparam logic [4:0] CODE_FIRST_VALID = 5'h04;
  localparam logic [4:0] CODE_LAST_FINE = 5'h0D;
  localparam logic [4:0] CODE_FINE_OFFSET = 5'h03;
  localparam logic [4:0] CODE_COARSE_OFFSET = 5'h08;
  localparam logic [4:0] CODE_TOP_MINUS1 = 5'h1E;
  localparam logic [4:0] CODE_TOP = 5'h1F;
  localparam logic [5:0] CUR_TOP_MINUS1 = 6'h2E;
  localparam logic [5:0] CUR_TOP = 6'h32;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 40000000;
  localparam int MS_PER_SEC = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_SEC;
  localparam logic [5:0] STEP_MS_SLOW = 6'h08;
  localparam logic [5:0] STEP_MS_MID = 6'h10;
  localparam logic [5:0] STEP_MS_FAST = 6'h20;

  // ==========================================================
  // group of a sink and fade codes
  typedef enum logic [1:0] {
    GRP_MAIN = 2'b00,
    GRP_SUB = 2'b01,
    GRP_THIRD = 2'b10
  } lsf_group_t;

  typedef enum logic [1:0] {
    FADE_OFF = 2'b00,
    FADE_8MS = 2'b01,
    FADE_16MS = 2'b10,
    FADE_32MS = 2'b11
  } lsf_fade_t;

endpackage : lsf_pkg

/* File: design/lsf_sink_out.sv */
// one sink: picks its group level, gates by enable, decodes to current
`timescale 1ns/1ps
module lsf_sink_out (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire lsf_pkg::lsf_group_t group,
  input wire logic enable,
  input wire logic [4:0] mainCode,
  input wire logic [4:0] subCode,
  input wire logic [4:0] thirdCode,
  output logic active,
  output logic [5:0] currentHalfMa
);
  import lsf_pkg::*;

  logic [4:0] code;

  // code 0 and the reserved codes 1..3 give no current
  function automatic logic [5:0] decodeLevel(input logic [4:0] c);
    logic [5:0] r;
    r = 6'h00;
    if (c == CODE_TOP)
      r = CUR_TOP;
    else if (c == CODE_TOP_MINUS1)
      r = CUR_TOP_MINUS1;
    else if (c > CODE_LAST_FINE)
      r = {c - CODE_COARSE_OFFSET, 1'b0};
    else if (c >= CODE_FIRST_VALID)
      r = {1'b0, c - CODE_FINE_OFFSET};
    return r;
  endfunction : decodeLevel

  always_comb begin
    case (group)
      GRP_SUB: code = subCode; // [R1]
      GRP_THIRD: code = thirdCode; // [R2]
      default: code = mainCode;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      active <= 1'b0;
      currentHalfMa <= 6'h00;
    end else begin
      active <= enable && (decodeLevel(code) != 6'h00); // [R4] [R16] [R20]
      currentHalfMa <= enable ? decodeLevel(code) : 6'h00; // [R3] [R4]
    end
  end

endmodule : lsf_sink_out

/* File: tb/lsf_config_props.sv */
// concurrent checks on the ports of the led sink config block
`timescale 1ns/1ps
module lsf_config_props #(
  parameter int MS_TICK_CYCLES = 4
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic wrValid,
  input wire logic [5:0] wrAddr,
  input wire logic [5:0] wrData,
  input wire logic [4:0] sinkActive,
  input wire logic [4:0][5:0] sinkCurrent,
  input wire logic [4:0] mainLevelCode,
  input wire logic fadeBusy
);
  import lsf_pkg::*;
  localparam int MIN_GAP = 8 * MS_TICK_CYCLES;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [1:0] fadeQ;
  logic [4:0] tgtQ;
  int gapQ;
  int idleQ;
  logic [4:0] nz;
  logic [4:0] bad;
  // ========
  // shadows of write-only fields, since nothing can be read back
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fadeQ <= 2'h0;
      tgtQ <= 5'h00;
      idleQ <= 0;
    end else begin
      if (wrValid && wrAddr == ADDR_MAIN_FADE_CONTROL) fadeQ <= wrData[1:0];
      if (wrValid && wrAddr == ADDR_MAIN_LEVEL) tgtQ <= wrData[4:0];
      idleQ <= wrValid ? 0 : (idleQ < 15 ? idleQ + 1 : idleQ);
    end
  end
  always_ff @(posedge core_clk) begin
    gapQ <= $changed(mainLevelCode) ? 1 : gapQ + 1;
  end
  // 22 and 24 mA and odd half-mA above 5 mA have no code
  always_comb begin
    for (int s = 0; s < 5; s++) begin
      nz[s] = |sinkCurrent[s];
      bad[s] = sinkCurrent[s] > CUR_TOP || (sinkCurrent[s] > 6'h0A && sinkCurrent[s][0]) ||
               sinkCurrent[s] == 6'h2C || sinkCurrent[s] == 6'h30;
    end
  end
  sequence s_step;
    $changed(mainLevelCode) && fadeQ != 2'h0;
  endsequence
  a_reset_zero: assert property (disable iff (1'b0) sys_rst |=> sinkActive == 5'h00 &&
    sinkCurrent == '0 && mainLevelCode == 5'h00 && !fadeBusy) else $error("outputs not cleared by reset");
  a_active_current: assert property (sinkActive == nz) else $error("active flag disagrees with current");
  a_level_legal: assert property (bad == 5'h00) else $error("sink current not a decodable level");
  a_step_unit: assert property (s_step |-> mainLevelCode == $past(mainLevelCode) + 5'h01 ||
    mainLevelCode == $past(mainLevelCode) - 5'h01) else $error("fade moved more than one code");
  a_step_spacing: assert property (s_step |-> gapQ >= MIN_GAP) else $error("fade step came too early");
  a_fade_off_jump: assert property (wrValid && wrAddr == ADDR_MAIN_LEVEL && fadeQ == 2'h0 |-> ##2
    mainLevelCode == tgtQ) else $error("main code did not jump with fade off");
  a_busy_settles: assert property ($fell(fadeBusy) |-> ##[0:1] mainLevelCode == tgtQ)
    else $error("fade ended away from target");
  a_quiet_stable: assert property (idleQ > 3 && fadeQ == 2'h0 |-> $stable(sinkCurrent))
    else $error("current changed with no write and no fade");
endmodule : lsf_config_props

/* File: tb/lsf_config_top_tb.sv */
// self-checking bench for the led sink config block
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) begin \
      fail_count++; \
      $display("unexpected %s exp %0h got %0h", nm, ex, got); \
    end \
  end
module lsf_config_top_tb;
  import lsf_pkg::*;
  localparam int T = 4;
  localparam logic [9:0] GRP [8] = '{10'h000, 10'h140, 10'h250, 10'h090, 10'h140, 10'h100, 10'h000, 10'h000};
  logic core_clk;
  logic sys_rst;
  logic wrValid;
  logic [5:0] wrAddr;
  logic [5:0] wrData;
  logic [4:0] sinkActive;
  logic [4:0][5:0] sinkCurrent;
  logic [4:0] mainLevelCode;
  logic fadeBusy;
  int fail_count;
  int n_checks;
  lsf_host i_host (.core_clk(core_clk), .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData));
  lsf_config_top #(.MS_TICK_CYCLES(T)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .wrValid(wrValid),
    .wrAddr(wrAddr), .wrData(wrData), .sinkActive(sinkActive), .sinkCurrent(sinkCurrent),
    .mainLevelCode(mainLevelCode), .fadeBusy(fadeBusy));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ========
  function automatic logic [5:0] cur(input logic [4:0] c);
    if (c < 5'h04) return 6'h00;
    if (c <= 5'h0D) return {1'b0, c} - 6'h03;
    if (c <= 5'h1D) return {c, 1'b0} - 6'h10;
    return c == 5'h1E ? 6'h2E : 6'h32;
  endfunction : cur
  task automatic w(input logic [5:0] a, input logic [5:0] d);
    i_host.write(a, d);
  endtask : w
  task automatic settle();
    repeat (3) @(negedge core_clk);
  endtask : settle
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // waits for the next main code change, bounded by hi + 1 cycles
  task automatic step(input logic [4:0] ex, input int lo, input int hi);
    int n;
    logic [4:0] was;
    was = mainLevelCode;
    n = 0;
    while (mainLevelCode === was && n <= hi) begin
      @(negedge core_clk);
      n++;
    end
    `CHK("main", ex, mainLevelCode)
    `CHK("gap", 1'b1, n >= lo && n <= hi)
    if (n > hi) conclude();
  endtask : step
  task automatic t_reset();
    @(negedge core_clk);
    `CHK("cur", '0, sinkCurrent)
    w(ADDR_SINK_ENABLE, 6'h1F);
    w(ADDR_MAIN_LEVEL, 6'h1F);
    settle();
    `CHK("all main", {5{6'h32}}, sinkCurrent)
    $display("test reset done");
  endtask : t_reset
  task automatic t_decode();
    // reserved codes 1..3 are never sent by the host
    for (int c = 0; c < 32; c += (c == 0) ? 4 : 1) begin
      w(ADDR_MAIN_LEVEL, 6'(c));
      settle();
      `CHK("decode", cur(5'(c)), sinkCurrent[0])
      `CHK("active", cur(5'(c)) != 6'h00, sinkActive[0])
    end
    $display("test decode done");
  endtask : t_decode
  task automatic t_groups();
    logic [4:0] en;
    logic [1:0] g;
    logic [4:0] gc;
    w(ADDR_SUB_GROUP_LEVEL, 6'h0D);
    w(ADDR_THIRD_GROUP_LEVEL, 6'h04);
    for (int m = 0; m < 8; m++) begin
      en = 5'h1F & ~(5'h01 << (m % 5));
      w(ADDR_SINK_ENABLE, {1'b0, en});
      w(ADDR_SINK_GROUP_MAP, 6'(m));
      w(6'h06, 6'h00);
      settle();
      for (int s = 0; s < 5; s++) begin
        g = GRP[m][2*s+:2];
        gc = g == 2'd0 ? 5'h1F : (g == 2'd1 ? 5'h0D : 5'h04);
        `CHK("sink", en[s] ? cur(gc) : 6'h00, sinkCurrent[s])
      end
    end
    $display("test groups done");
  endtask : t_groups
  task automatic t_fade();
    int iv;
    w(ADDR_SINK_GROUP_MAP, 6'h01);
    w(ADDR_SINK_ENABLE, 6'h1F);
    w(ADDR_MAIN_LEVEL, 6'h04);
    for (int r = 1; r < 4; r++) begin
      iv = (8 << (r - 1)) * T;
      w(ADDR_MAIN_FADE_CONTROL, 6'(r));
      w(ADDR_MAIN_LEVEL, r == 2 ? 6'h04 : 6'h06);
      step(r == 2 ? 5'h05 : 5'h05, iv, iv + 3);
      `CHK("busy", 1'b1, fadeBusy)
      step(r == 2 ? 5'h04 : 5'h06, iv, iv);
    end
    iv = 8 * T;
    w(ADDR_MAIN_FADE_CONTROL, 6'h01);
    w(ADDR_MAIN_LEVEL, 6'h0A);
    w(ADDR_SUB_GROUP_LEVEL, 6'h1F);
    settle();
    `CHK("sub jump", 6'h32, sinkCurrent[3])
    `CHK("main held", 5'h06, mainLevelCode)
    step(5'h07, iv - 8, iv + 3);
    w(ADDR_MAIN_LEVEL, 6'h05);
    step(5'h06, iv - 4, iv);
    step(5'h05, iv, iv);
    settle();
    `CHK("idle", 1'b0, fadeBusy)
    w(ADDR_MAIN_LEVEL, 6'h14);
    w(ADDR_MAIN_FADE_CONTROL, 6'h00);
    settle();
    `CHK("off jump", cur(5'h14), sinkCurrent[0])
    $display("test fade done");
  endtask : t_fade
  // reset in mid-run must clear the levels, the fade code and the grouping
  task automatic t_midreset();
    w(ADDR_SUB_GROUP_LEVEL, 6'h1F);
    w(ADDR_THIRD_GROUP_LEVEL, 6'h1F);
    w(ADDR_MAIN_FADE_CONTROL, 6'h01);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    `CHK("rst cur", '0, sinkCurrent)
    `CHK("rst act", 5'h00, sinkActive)
    `CHK("rst main", 5'h00, mainLevelCode)
    w(ADDR_SINK_ENABLE, 6'h1F);
    w(ADDR_MAIN_LEVEL, 6'h1F);
    settle();
    `CHK("rst map", {5{6'h32}}, sinkCurrent)
    w(ADDR_SINK_GROUP_MAP, 6'h02);
    settle();
    `CHK("rst levels", {6'h00, 6'h00, 6'h00, 6'h32, 6'h32}, sinkCurrent)
    $display("test midreset done");
  endtask : t_midreset
  initial begin
    fail_count = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_decode();
    t_groups();
    t_fade();
    t_midreset();
    conclude();
  end
endmodule : lsf_config_top_tb
bind lsf_config_top lsf_config_props #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) i_props (.core_clk(core_clk),
  .sys_rst(sys_rst), .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData), .sinkActive(sinkActive),
  .sinkCurrent(sinkCurrent), .mainLevelCode(mainLevelCode), .fadeBusy(fadeBusy));

/* File: tb/lsf_host.sv */
// host model: sends paired address and data writes
`timescale 1ns/1ps
module lsf_host (
  input wire logic core_clk,
  output logic wrValid,
  output logic [5:0] wrAddr,
  output logic [5:0] wrData
);
  import lsf_pkg::*;
  initial begin
    wrValid = 1'b0;
    wrAddr = 6'h3F;
    wrData = 6'h3F;
  end
  // unused upper data bits always sent as zero
  task automatic write(input logic [5:0] a, input logic [5:0] d);
    logic [5:0] m;
    m = a == ADDR_MAIN_FADE_CONTROL ? 6'h03 : (a == ADDR_SINK_GROUP_MAP ? 6'h07 : 6'h1F);
    @(posedge core_clk);
    wrValid <= 1'b1;
    wrAddr <= a;
    wrData <= d & m;
    @(posedge core_clk);
    wrValid <= 1'b0;
    wrAddr <= ~a;
    wrData <= ~(d & m);
  endtask : write
endmodule : lsf_host
